// >>> srp_builder.sv
// response packet builder: software fills fields over Avalon-MM and
// starts a packet; framed bytes leave on a valid/ready byte stream.
// assumes a synchronous Avalon master and a serialiser draining tx.
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "srp_params.svh"
module srp_builder
    import srp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // avalon-mm slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // byte stream to the serial link
    output logic [7:0] tx_data_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in
);

    srp_state_t st_r; // registered state
    srp_state_t st_nxt; // next state

    // merge write data under byte enables
    function automatic logic [31:0] be_merge(logic [31:0] o, logic [31:0] n,
                                             logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b+:8] = n[8*b+:8];
            end
        end
        return r;
    endfunction : be_merge

    // one byte through crc-ccitt, msb first
    function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int b = 0; b < 8; b++) begin
            r = r[15] ? ((r << 1) ^ `SRP_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    // text length N: release text, one space, part number
    function automatic logic [7:0] text_len(srp_state_t s);
        return s.regs[`SRP_REG_TEXT_CFG][7:0] + s.regs[`SRP_REG_TEXT_CFG][15:8] + 8'h01;
    endfunction : text_len

    // payload length per kind
    function automatic logic [7:0] len_of(srp_state_t s, srp_kind_t k);
        unique case (k)
            SRP_K_CAL: return `SRP_LEN_CAL;
            SRP_K_NAK: return `SRP_LEN_NAK;
            SRP_K_ID: return `SRP_LEN_ID_BASE + text_len(s);
            SRP_K_VR: return `SRP_LEN_VR;
            SRP_K_T0: return `SRP_LEN_T0;
        endcase
    endfunction : len_of

    // type code per kind
    function automatic logic [15:0] type_of(srp_kind_t k);
        unique case (k)
            SRP_K_CAL: return `SRP_TYPE_CAL;
            SRP_K_NAK: return `SRP_TYPE_NAK;
            SRP_K_ID: return `SRP_TYPE_ID;
            SRP_K_VR: return `SRP_TYPE_VR;
            SRP_K_T0: return `SRP_TYPE_T0;
        endcase
    endfunction : type_of

    // payload byte i of the packet in flight
    function automatic logic [7:0] pay_byte(srp_state_t s, logic [7:0] i);
        logic [15:0] w;
        logic [7:0] rl;
        logic [7:0] t;
        logic rel;
        w = 16'h0000;
        rl = s.regs[`SRP_REG_TEXT_CFG][7:0];
        t = i - 8'h04;
        rel = s.regs[`SRP_REG_VER_B][8];
        unique case (s.kind)
            SRP_K_CAL: begin
                unique case (i[3:1])
                    // auto flag picks the task code
                    3'h0: w = s.regs[`SRP_REG_CAL_A][0] ? `SRP_TASK_AUTO : `SRP_TASK_MANUAL;
                    // hard offsets at 2 and 4
                    3'h1: w = s.regs[`SRP_REG_CAL_B][31:16];
                    3'h2: w = s.regs[`SRP_REG_CAL_B][15:0];
                    3'h3: w = s.regs[`SRP_REG_CAL_C][31:16];
                    default: w = s.regs[`SRP_REG_CAL_C][15:0];
                endcase
            end
            SRP_K_NAK: w = s.rej;
            SRP_K_T0: begin
                // word j sits in register BIT0 + j/2, high half first
                w = i[1] ? s.regs[`SRP_REG_BIT0 + 5'(i[4:2])][15:0]
                         : s.regs[`SRP_REG_BIT0 + 5'(i[4:2])][31:16];
            end
            default: w = 16'h0000;
        endcase
        if (s.kind == SRP_K_ID) begin
            if (i < 8'h04) begin
                return s.regs[`SRP_REG_SERIAL][8*(3-i[1:0])+:8];
            end else if (t >= text_len(s)) begin
                return 8'h00;
            end else if (t < rl) begin
                return s.text[t[4:0]];
            end else if (t == rl) begin
                return `SRP_SPACE_BYTE;
            end else begin
                return s.text[5'(t - 8'h01)];
            end
        end
        if (s.kind == SRP_K_VR) begin
            unique case (i[2:0])
                3'h0: return s.regs[`SRP_REG_VER_A][31:24];
                3'h1: return s.regs[`SRP_REG_VER_A][23:16];
                3'h2: return s.regs[`SRP_REG_VER_A][15:8];
                // two-bit stage code; released reads zero
                3'h3: return rel ? 8'h00 : {6'h00, s.regs[`SRP_REG_VER_B][1:0]};
                default: return rel ? 8'h00 : s.regs[`SRP_REG_VER_A][7:0];
            endcase
        end
        return i[0] ? w[7:0] : w[15:8];
    endfunction : pay_byte

    // framed byte at position idx
    function automatic logic [7:0] frame_byte(srp_state_t s, logic [8:0] idx);
        logic [8:0] len;
        logic [15:0] ty;
        len = {1'b0, len_of(s, s.kind)};
        ty = type_of(s.kind);
        if (idx < 9'h002) begin
            return `SRP_PREAMBLE_BYTE;
        end else if (idx == 9'h002) begin
            return ty[15:8];
        end else if (idx == 9'h003) begin
            return ty[7:0];
        end else if (idx == 9'h004) begin
            return len[7:0];
        end else if (idx < len + 9'h005) begin
            return pay_byte(s, 8'(idx - 9'h005));
        end else if (idx == len + 9'h005) begin
            return s.crc[15:8];
        end else begin
            return s.crc[7:0];
        end
    endfunction : frame_byte

    // next-state logic: bus slave, command launch, byte sequencer
    always_comb begin
        logic [4:0] ri;
        logic [31:0] rd;
        logic [8:0] total;
        logic [7:0] b;
        logic [15:0] pt;
        st_nxt = st_r;
        ri = avs_address_in[6:2];
        rd = 32'h0000_0000;
        total = {1'b0, len_of(st_r, st_r.kind)} + 9'h007;
        b = 8'h00;
        pt = st_r.regs[`SRP_REG_POLL][15:0];
        // read mux; unmapped addresses read zero
        if (!avs_address_in[7] && ri < 5'(`SRP_NREG)) begin
            if (ri == `SRP_REG_STATUS) begin
                rd = {16'h0000, st_r.sent, 6'h00, st_r.refused, st_r.fsm == SRP_SEND};
            end else if (ri != `SRP_REG_TEXT_WR) begin
                rd = st_r.regs[ri];
            end
        end
        if (st_r.ack) begin
            // access completes this edge; raise waitrequest again
            st_nxt.ack = 1'b0;
            if (avs_write_in && !avs_address_in[7] && ri < 5'(`SRP_NREG)) begin
                if (ri == `SRP_REG_TEXT_WR) begin
                    st_nxt.text[avs_writedata_in[12:8]] = avs_writedata_in[7:0];
                end else if (ri != `SRP_REG_STATUS) begin
                    st_nxt.regs[ri] = be_merge(st_r.regs[ri], avs_writedata_in,
                                               avs_byteenable_in);
                end
                if (ri == `SRP_REG_CMD) begin
                    st_nxt.refused = 1'b0;
                    st_nxt.fsm = SRP_SEND;
                    st_nxt.idx = 9'h000;
                    st_nxt.crc = `SRP_CRC_INIT;
                    st_nxt.rej = st_r.regs[`SRP_REG_NAK][15:0];
                    unique case (avs_writedata_in[2:0])
                        `SRP_CMD_CAL: st_nxt.kind = SRP_K_CAL;
                        `SRP_CMD_NAK: st_nxt.kind = SRP_K_NAK;
                        `SRP_CMD_POLL: begin
                            if (pt == `SRP_TYPE_ID) begin
                                st_nxt.kind = SRP_K_ID;
                            end else if (pt == `SRP_TYPE_VR) begin
                                st_nxt.kind = SRP_K_VR;
                            end else if (pt == `SRP_TYPE_T0) begin
                                st_nxt.kind = SRP_K_T0;
                            end else begin
                                // unknown poll refused with poll type
                                st_nxt.kind = SRP_K_NAK;
                                st_nxt.rej = `SRP_TYPE_POLL;
                                st_nxt.refused = 1'b1;
                            end
                        end
                        default: st_nxt.fsm = SRP_IDLE;
                    endcase
                end
            end
        end else if (avs_read_in || avs_write_in) begin
            // a command waits while a packet is still going out
            if (!(avs_write_in && ri == `SRP_REG_CMD && !avs_address_in[7]
                  && st_r.fsm == SRP_SEND)) begin
                st_nxt.ack = 1'b1;
                st_nxt.rdata = rd;
            end
        end
        // byte sequencer: load when the output slot is free
        if (st_r.fsm == SRP_SEND && (!st_r.tx.valid || tx_ready_in)) begin
            if (st_r.idx < total) begin
                b = frame_byte(st_r, st_r.idx);
                st_nxt.tx.data = b;
                st_nxt.tx.valid = 1'b1;
                st_nxt.idx = st_r.idx + 9'h001;
                // crc covers type, length and payload
                if (st_r.idx >= 9'h002 && st_r.idx < total - 9'h002) begin
                    st_nxt.crc = crc_step(st_r.crc, b);
                end
            end else begin
                st_nxt.tx.valid = 1'b0;
                st_nxt.fsm = SRP_IDLE;
                st_nxt.sent = st_r.sent + 8'h01;
            end
        end else if (st_r.fsm == SRP_IDLE && tx_ready_in) begin
            st_nxt.tx.valid = 1'b0;
        end
    end

    // state register; everything resets to zero and idle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign avs_readdata_out = st_r.rdata;
    assign avs_waitrequest_out = !st_r.ack;
    assign tx_data_out = st_r.tx.data;
    assign tx_valid_out = st_r.tx.valid;

endmodule : srp_builder
`default_nettype wire

// >>> srp_params.svh
// constants for the response packet builder: offsets, codes, counts
// assumes inclusion by srp_pkg.sv and srp_builder.sv
`ifndef SRP_PARAMS_SVH
`define SRP_PARAMS_SVH
// frame constants
`define SRP_PREAMBLE_BYTE 8'h55
`define SRP_SPACE_BYTE 8'h20
`define SRP_CRC_INIT 16'h1D0F
`define SRP_CRC_POLY 16'h1021
// packet type codes and payload lengths
`define SRP_TYPE_CAL 16'h4344
`define SRP_LEN_CAL 8'h0A
`define SRP_TYPE_NAK 16'h1515
`define SRP_LEN_NAK 8'h02
`define SRP_TYPE_ID 16'h4944
`define SRP_LEN_ID_BASE 8'h05
`define SRP_TYPE_VR 16'h5652
`define SRP_LEN_VR 8'h05
`define SRP_TYPE_T0 16'h5430
`define SRP_LEN_T0 8'h1C
`define SRP_TYPE_POLL 16'h4750
// calibration task codes
`define SRP_TASK_MANUAL 16'h000B
`define SRP_TASK_AUTO 16'h000C
// command codes written to the command register
`define SRP_CMD_CAL 3'h1
`define SRP_CMD_NAK 3'h2
`define SRP_CMD_POLL 3'h3
// register word indices (byte address is four times the index)
`define SRP_REG_CMD 5'h00
`define SRP_REG_STATUS 5'h01
`define SRP_REG_CAL_A 5'h02
`define SRP_REG_CAL_B 5'h03
`define SRP_REG_CAL_C 5'h04
`define SRP_REG_NAK 5'h05
`define SRP_REG_POLL 5'h06
`define SRP_REG_SERIAL 5'h07
`define SRP_REG_VER_A 5'h08
`define SRP_REG_VER_B 5'h09
`define SRP_REG_TEXT_CFG 5'h0A
`define SRP_REG_TEXT_WR 5'h0B
`define SRP_REG_BIT0 5'h0C
`define SRP_NREG 19
// text storage depth in bytes
`define SRP_TEXT_DEPTH 32
`endif

// >>> srp_pkg.sv
// types shared by the response packet builder
// assumes srp_params.svh in the include path
`include "srp_params.svh"
package srp_pkg;
    // packet kinds the builder can send
    typedef enum logic [2:0] {SRP_K_CAL, SRP_K_NAK, SRP_K_ID, SRP_K_VR, SRP_K_T0} srp_kind_t;
    // sequencer states
    typedef enum logic {SRP_IDLE, SRP_SEND} srp_fsm_t;
    // byte stream towards the serial link
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } srp_tx_t;
    // whole state of the builder
    typedef struct packed {
        logic [`SRP_NREG-1:0][31:0] regs;
        logic [`SRP_TEXT_DEPTH-1:0][7:0] text;
        logic ack;
        logic [31:0] rdata;
        srp_fsm_t fsm;
        srp_kind_t kind;
        logic [15:0] rej;
        logic [8:0] idx;
        logic [15:0] crc;
        srp_tx_t tx;
        logic refused;
        logic [7:0] sent;
    } srp_state_t;
endpackage : srp_pkg

// >>> srp_builder_asserts.sv
// checker for the packet builder: framing, lengths, bus wait pulse
// sees only builder ports; bound to every srp_builder below
`timescale 1ns/100ps
`default_nettype none
module srp_builder_asserts (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // bus side
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    // stream side
    input wire logic [7:0] tx_data_out,
    input wire logic tx_valid_out,
    input wire logic tx_ready_in
);
    logic [8:0] idx_r; // byte position inside the frame
    logic [15:0] typ_r; // type code of the frame in flight
    // count accepted bytes; the stream idles between frames, which restarts the count
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idx_r <= 9'h000;
            typ_r <= 16'h0000;
        end else if (!tx_valid_out) begin
            idx_r <= 9'h000;
        end else if (tx_ready_in) begin
            idx_r <= idx_r + 9'h001;
            // type bytes sit at positions 2 and 3
            if (idx_r == 9'h002 || idx_r == 9'h003) begin
                typ_r <= {typ_r[7:0], tx_data_out};
            end
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    preamble_ok_a: assert property (tx_valid_out && idx_r < 9'h002 |-> tx_data_out == 8'h55)
        else $error("preamble byte wrong");
    type_known_a: assert property (tx_valid_out && idx_r == 9'h002 |->
        tx_data_out inside {8'h43, 8'h15, 8'h49, 8'h56, 8'h54}) else $error("unknown type");
    cal_len_a: assert property (tx_valid_out && idx_r == 9'h004 && typ_r == 16'h4344 |->
        tx_data_out == 8'h0A) else $error("calibration length wrong");
    nak_len_a: assert property (tx_valid_out && idx_r == 9'h004 && typ_r == 16'h1515 |->
        tx_data_out == 8'h02) else $error("nak length wrong");
    rev_len_a: assert property (tx_valid_out && idx_r == 9'h004 && typ_r == 16'h5652 |->
        tx_data_out == 8'h05) else $error("revision length wrong");
    test_len_a: assert property (tx_valid_out && idx_r == 9'h004 && typ_r == 16'h5430 |->
        tx_data_out == 8'h1C) else $error("selftest length wrong");
    task_code_a: assert property (tx_valid_out && idx_r == 9'h006 && typ_r == 16'h4344 |->
        tx_data_out inside {8'h0B, 8'h0C}) else $error("task code wrong");
    byte_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
        tx_valid_out && $stable(tx_data_out)) else $error("byte dropped while stalled");
    wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("wait low too long");
    wait_cause_a: assert property ($fell(avs_waitrequest_out) |->
        $past(avs_read_in || avs_write_in)) else $error("answer without request");
    cover property (tx_valid_out && idx_r == 9'h004 && typ_r == 16'h4944);
    cover property (tx_valid_out && !tx_ready_in);
    cover property (tx_valid_out && idx_r == 9'h004 && typ_r == 16'h1515);
endmodule : srp_builder_asserts
bind srp_builder srp_builder_asserts i_srp_builder_asserts (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out),
    .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out),
    .tx_ready_in(tx_ready_in)
);
`default_nettype wire

// >>> srp_sink.sv
// host link partner: takes framed bytes, may stall
// assumes the bench drives stall_in and reads q
`timescale 1ns/100ps
`default_nettype none
module srp_sink (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // stream from the builder
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    input wire logic stall_in,
    output logic ready_out
);
    logic [7:0] q[$]; // bytes taken, in arrival order
    // ready moves only after an edge, as a real serialiser would
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_out <= 1'b0;
        end else begin
            if (tx_valid_in && ready_out) begin
                q.push_back(tx_data_in);
            end
            ready_out <= !stall_in;
        end
    end
endmodule : srp_sink
`default_nettype wire

// >>> tb.sv
// bench for the packet builder: fields set over the bus, frames compared
// assumes srp_sink as link partner and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_in, rd = 1'b0, wr = 1'b0, wt, vld, rdy, stl = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] adr = 8'h00, txd;
    logic [3:0] be = 4'hF; // byte enables, full word unless a case narrows them
    logic [31:0] wd = 32'h0, rdd, sr = 32'h000176DF;
    logic [7:0] eq[$], p[$];
    int n_fail = 0, checks_done = 0, nf = 0;
    srp_builder i_srp_builder (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdd), .avs_waitrequest_out(wt),
        .tx_data_out(txd), .tx_valid_out(vld), .tx_ready_in(rdy));
    srp_sink i_srp_sink (.clk_in(clk_in), .rst_n_in(rst_n_in), .tx_data_in(txd),
        .tx_valid_in(vld), .stall_in(stl), .ready_out(rdy));
    // verdict and end of run
    task automatic close_out();
        if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // compare seen against expected
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // next pseudo-random word
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    // one bus cycle, held until wait is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        int k;
        @(posedge clk_in);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (wt !== 1'b0 && k < 3000);
        r = rdd;
        wr <= 1'b0;
        rd <= 1'b0;
        if (k >= 3000) begin
            n_fail++;
            close_out();
        end
    endtask : bus
    // payload word, high byte first
    task automatic push16(input logic [15:0] v);
        p.push_back(v[15:8]);
        p.push_back(v[7:0]);
    endtask : push16
    // expected frame: preamble, type, length, payload, crc over type..payload
    task automatic frame(input logic [15:0] t);
        logic [15:0] c;
        logic [7:0] b[$];
        b = {t[15:8], t[7:0], 8'(p.size())};
        b = {b, p};
        c = 16'h1D0F;
        foreach (b[i]) for (int j = 7; j >= 0; j--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][j]) ? 16'h1021 : 16'h0000);
        eq = {eq, 8'h55, 8'h55, b, c[15:8], c[7:0]};
        p = {};
        nf++;
    endtask : frame
    // wait for every expected byte, then compare in order
    task automatic drain();
        int k;
        for (k = 0; k < 9000 && i_srp_sink.q.size() < eq.size(); k++) @(posedge clk_in);
        repeat (4) @(posedge clk_in);
        chk("byte count", i_srp_sink.q.size(), eq.size());
        foreach (eq[i]) chk("frame byte", i_srp_sink.q[i], eq[i]);
        eq = {};
        i_srp_sink.q.delete();
        if (k >= 9000) begin
            n_fail++;
            close_out();
        end
    endtask : drain
    // host poll and the answer it should bring
    task automatic poll(input logic [15:0] t, input logic [15:0] f);
        logic [31:0] r;
        bus(1'b1, 8'h18, {16'h0, t}, r);
        bus(1'b1, 8'h00, 32'h00000003, r);
        frame(f);
        drain();
    endtask : poll
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // link stalls about a quarter of cycles
    always @(posedge clk_in) begin
        sr <= nx(sr);
        stl <= sr[0] & sr[3];
    end
    initial begin
        logic [31:0] r, s, e;
        int i;
        s = 32'h000176DF;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        bus(1'b0, 8'h04, 32'h0, r);
        chk("status idle", r, 32'h0);
        bus(1'b1, 8'h80, s, r);
        bus(1'b0, 8'h80, 32'h0, r);
        chk("unmapped", r, 32'h0);
        // both task codes, nak queued behind each report
        for (i = 0; i < 2; i++) begin
            bus(1'b1, 8'h08, 32'(i), r);
            push16(i ? 16'h000C : 16'h000B);
            s = nx(s);
            bus(1'b1, 8'h0C, s, r);
            push16(s[31:16]);
            push16(s[15:0]);
            s = nx(s);
            bus(1'b1, 8'h10, s, r);
            push16(s[31:16]);
            push16(s[15:0]);
            bus(1'b1, 8'h00, 32'h00000001, r);
            frame(16'h4344);
            bus(1'b1, 8'h14, s ^ 32'h0000A5C3, r);
            push16(s[15:0] ^ 16'hA5C3);
            bus(1'b1, 8'h00, 32'h00000002, r);
            frame(16'h1515);
            drain();
        end
        // every stage code, then released firmware
        for (i = 0; i < 5; i++) begin
            s = nx(s);
            bus(1'b1, 8'h20, s, r);
            bus(1'b1, 8'h24, (i == 4) ? {23'h0, 1'b1, 6'h0, s[1:0]} : 32'(i), r);
            p = {s[31:24], s[23:16], s[15:8], (i == 4) ? 8'h00 : 8'(i), (i == 4) ? 8'h00 : s[7:0]};
            poll(16'h5652, 16'h5652);
        end
        for (i = 0; i < 7; i++) begin
            s = nx(s);
            bus(1'b1, 8'(8'h30 + 4 * i), s, r);
            push16(s[31:16]);
            push16(s[15:0]);
        end
        poll(16'h5430, 16'h5430);
        // serial written whole, then lanes 0 and 2 only: untouched lanes must survive
        s = nx(s);
        bus(1'b1, 8'h1C, s, r);
        e = s;
        s = nx(s);
        be <= 4'h5;
        bus(1'b1, 8'h1C, s, r);
        be <= 4'hF;
        e = {e[31:24], s[23:16], e[15:8], s[7:0]};
        push16(e[31:16]);
        push16(e[15:0]);
        bus(1'b1, 8'h28, 32'h00000403, r);
        for (i = 0; i < 7; i++) begin
            s = nx(s);
            bus(1'b1, 8'h2C, {19'h0, 5'(i), s[7:0]}, r);
            p.push_back(s[7:0]);
            if (i == 2) p.push_back(8'h20);
        end
        p.push_back(8'h00);
        poll(16'h4944, 16'h4944);
        // unused command sends nothing; unknown poll is refused
        bus(1'b1, 8'h00, 32'h00000004, r);
        push16(16'h4750);
        poll(16'h1234, 16'h1515);
        bus(1'b0, 8'h04, 32'h0, r);
        chk("status after refusal", r[15:0], {8'(nf), 8'h02});
        close_out();
    end
endmodule : tb
`default_nettype wire
